/* strobe_frame_pkg.sv */
// Constants shared by the strobe frame output stage.
package strobe_frame_pkg;
  localparam int NBUS = 4;
  localparam int SW = 12;
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte addresses.
  localparam logic [7:0] PATTERN_CHOICE_ADDR = 8'h00;
  localparam logic [7:0] LINK_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] FRAME_LENGTH_ADDR = 8'h08;
  localparam logic [7:0] SWING_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  // Field positions.
  localparam int SRC_LSB = 0;
  localparam int SPI_REQ_BIT = 2;
  localparam int STB_EN_LSB = 4;
  localparam int ACT_BIT = 0;
  localparam int FCNT_LSB = 8;
  // Pattern, source and swing encodings.
  localparam logic [1:0] PAT_LSB = 2'h2;
  localparam logic [1:0] PAT_ALL = 2'h3;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_SPI = 2'h1;
  localparam logic [1:0] SRC_TS = 2'h2;
  localparam logic [1:0] SWING_HIGH = 2'h0;
  localparam logic [1:0] SWING_LOW = 2'h1;
  localparam logic [1:0] SWING_HIZ = 2'h3;
  // Reset values and pattern words.
  localparam logic [1:0] PAT_RST = 2'h0;
  localparam logic [1:0] SRC_RST = SRC_PIN;
  localparam logic [3:0] STB_EN_RST = 4'hF;
  localparam logic [7:0] FLEN_RST = 8'h08;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONES = 12'hFFF;
endpackage : strobe_frame_pkg

/* strobe_frame.sv */
// Strobe insertion and sync pattern framer with register port and link domain.
`timescale 1ns/100ps
module strobe_frame
  import strobe_frame_pkg::*;
(
  // Clocks and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic link_clk_in,
  // Register port
  input wire logic [strobe_frame_pkg::AW-1:0] addr_in,
  input wire logic [strobe_frame_pkg::DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [strobe_frame_pkg::DW-1:0] rdata_out,
  // Pins and sample source
  input wire logic system_reference_input_in,
  input wire logic single_ended_request_pin_in,
  input wire logic timestamp_input_in,
  input wire logic [strobe_frame_pkg::NBUS*strobe_frame_pkg::SW-1:0] sample_in,
  // Link outputs
  output logic [strobe_frame_pkg::NBUS*strobe_frame_pkg::SW-1:0] bus_sample_pairs_out,
  output logic [strobe_frame_pkg::NBUS-1:0] bus_frame_marker_pair_out,
  output logic [1:0] swing_out
);
  import strobe_frame_pkg::*;

  typedef struct packed {
    logic [1:0] pat;
    logic [1:0] src;
    logic spi_req;
    logic [3:0] stb_en;
    logic [7:0] flen;
    logic [1:0] swing;
    logic cfg_tog;
    logic [2:0] fr_s;
    logic [1:0] act_s;
    logic [7:0] fcnt;
    logic pend;
    logic [1:0] ack_s;
    logic [DW-1:0] rdata;
  } core_s;

  typedef struct packed {
    logic [2:0] sr_s;
    logic [1:0] pin_s;
    logic [1:0] ts_s;
    logic [1:0] spi_s;
    logic [2:0] tg_s;
    logic [1:0] pat;
    logic [1:0] src;
    logic [3:0] stb_en;
    logic [7:0] flen;
    logic [7:0] cnt;
    logic act;
    logic fr_tog;
    logic [NBUS*SW-1:0] dout;
    logic [NBUS-1:0] stb;
  } link_s;

  core_s core;
  core_s next_core;
  link_s lnk;
  link_s next_lnk;
  logic sr_edge;
  logic last_ui;
  logic req;
  logic act_c;
  logic [7:0] flm1;

  // A zero frame length would otherwise give a 256-UI frame, so it behaves as one UI.
  function automatic logic [7:0] last_index(input logic [7:0] len);
    last_index = (len == 8'h00) ? 8'h00 : len - 8'h01;
  endfunction : last_index

  function automatic logic pick_req(input logic [1:0] src, input logic pin,
                                    input logic spi, input logic ts);
    case (src)
      SRC_SPI: pick_req = spi;
      SRC_TS: pick_req = ts;
      default: pick_req = pin;
    endcase
  endfunction : pick_req

  // Register side.
  always_comb begin
    next_core = core;
    next_core.fr_s = {core.fr_s[1:0], lnk.fr_tog};
    next_core.act_s = {core.act_s[0], lnk.act};
    next_core.ack_s = {core.ack_s[0], lnk.tg_s[2]};
    // One crossing at a time: two toggles inside one link period would cancel out.
    if (core.pend && core.ack_s[1] == core.cfg_tog) begin
      next_core.cfg_tog = ~core.cfg_tog;
      next_core.pend = 1'b0;
    end
    if (core.fr_s[2] != core.fr_s[1]) begin
      next_core.fcnt = core.fcnt + 8'h01;
    end
    next_core.rdata = '0;
    if (wr_in) begin
      case (addr_in)
        PATTERN_CHOICE_ADDR: begin
          next_core.pat = wdata_in[1:0];
          next_core.pend = 1'b1;
        end
        LINK_CONTROL_ADDR: begin
          next_core.src = wdata_in[SRC_LSB +: 2];
          next_core.spi_req = wdata_in[SPI_REQ_BIT];
          next_core.stb_en = wdata_in[STB_EN_LSB +: NBUS];
          next_core.pend = 1'b1;
        end
        FRAME_LENGTH_ADDR: begin
          next_core.flen = wdata_in[7:0];
          next_core.pend = 1'b1;
        end
        SWING_ADDR: begin
          next_core.swing = wdata_in[1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        PATTERN_CHOICE_ADDR: next_core.rdata = {30'h0, core.pat};
        LINK_CONTROL_ADDR: next_core.rdata = {24'h0, core.stb_en, 1'b0,
                                              core.spi_req, core.src};
        FRAME_LENGTH_ADDR: next_core.rdata = {24'h0, core.flen};
        SWING_ADDR: next_core.rdata = {30'h0, core.swing};
        STATUS_ADDR: begin
          next_core.rdata[ACT_BIT] = core.act_s[1];
          next_core.rdata[FCNT_LSB +: 8] = core.fcnt;
        end
        default: next_core.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core <= '0;
      core.pat <= PAT_RST;
      core.src <= SRC_RST;
      core.stb_en <= STB_EN_RST;
      core.flen <= FLEN_RST;
      core.swing <= SWING_HIGH;
    end else begin
      core <= next_core;
    end
  end

  // Link side. Configuration words are read here only after the write
  // toggle has passed two flops, when the register values have settled.
  assign sr_edge = lnk.sr_s[1] & ~lnk.sr_s[2];
  assign flm1 = last_index(lnk.flen);
  assign last_ui = (lnk.cnt >= flm1);
  assign req = pick_req(lnk.src, lnk.pin_s[1], lnk.spi_s[1], lnk.ts_s[1]);
  // The sync pattern is sent only in the two substitution modes.
  assign act_c = req && (lnk.pat == PAT_LSB || lnk.pat == PAT_ALL);

  always_comb begin
    next_lnk = lnk;
    next_lnk.sr_s = {lnk.sr_s[1:0], system_reference_input_in};
    next_lnk.pin_s = {lnk.pin_s[0], single_ended_request_pin_in};
    next_lnk.ts_s = {lnk.ts_s[0], timestamp_input_in};
    next_lnk.spi_s = {lnk.spi_s[0], core.spi_req};
    next_lnk.tg_s = {lnk.tg_s[1:0], core.cfg_tog};
    if (lnk.tg_s[2] != lnk.tg_s[1]) begin
      next_lnk.pat = core.pat;
      next_lnk.src = core.src;
      next_lnk.stb_en = core.stb_en;
      next_lnk.flen = core.flen;
    end
    // A reference edge makes the next UI the first of a new frame.
    if (sr_edge) begin
      next_lnk.cnt = 8'h00;
    end else if (last_ui) begin
      next_lnk.cnt = 8'h00;
    end else begin
      next_lnk.cnt = lnk.cnt + 8'h01;
    end
    if (last_ui) begin
      next_lnk.fr_tog = ~lnk.fr_tog;
    end
    next_lnk.act = act_c;
    next_lnk.stb = lnk.stb_en & {NBUS{last_ui}};
    for (int b = 0; b < NBUS; b++) begin
      if (act_c && lnk.pat == PAT_ALL) begin
        // Samples in this UI are dropped; the receiver must tolerate it.
        next_lnk.dout[b*SW +: SW] = last_ui ? WORD_ONES : WORD_ZERO;
      end else if (act_c) begin
        next_lnk.dout[b*SW +: SW] = {sample_in[b*SW+1 +: SW-1], last_ui};
      end else begin
        next_lnk.dout[b*SW +: SW] = sample_in[b*SW +: SW];
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lnk <= '0;
      lnk.pat <= PAT_RST;
      lnk.src <= SRC_RST;
      lnk.stb_en <= STB_EN_RST;
      lnk.flen <= FLEN_RST;
    end else begin
      lnk <= next_lnk;
    end
  end

  assign rdata_out = core.rdata;
  assign swing_out = core.swing;
  assign bus_sample_pairs_out = lnk.dout;
  assign bus_frame_marker_pair_out = lnk.stb;

  strobe_last_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    1'b1 |=> bus_frame_marker_pair_out[0] == ($past(lnk.stb_en[0]) && $past(last_ui)))
    else $error("marker not tied to last UI");

  frame_wrap_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.cnt == flm1 && $stable(lnk.flen)) |=> lnk.cnt == 8'h00)
    else $error("frame counter did not wrap");

  system_reference_input_start_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    $rose(lnk.sr_s[1]) |=> lnk.cnt == 8'h00)
    else $error("reference edge did not restart frame");

  lsb_strobe_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (act_c && lnk.pat == PAT_LSB) |=> bus_sample_pairs_out[0] == $past(last_ui)
      && bus_sample_pairs_out[SW-1:1] == $past(sample_in[SW-1:1]))
    else $error("LSB strobe wrong");

  lsb_keep_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (!req && lnk.pat == PAT_LSB) |=> bus_sample_pairs_out[0] == $past(sample_in[0]))
    else $error("true LSB lost");

  allpair_word_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (act_c && lnk.pat == PAT_ALL) |=>
      bus_sample_pairs_out[SW-1:0] == ($past(last_ui) ? WORD_ONES : WORD_ZERO))
    else $error("all-pairs word wrong");

  full_width_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    !act_c |=> bus_sample_pairs_out == $past(sample_in))
    else $error("sample altered while idle");

  pin_default_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.src == SRC_PIN && lnk.pat == PAT_ALL) |-> act_c == lnk.pin_s[1])
    else $error("request not from pin");

  swing_write_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_in && addr_in == SWING_ADDR) |=> swing_out == $past(wdata_in[1:0]))
    else $error("swing not updated");

  read_slot_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !rd_in |=> rdata_out == '0)
    else $error("read data outside slot");

  // A new toggle may only leave once the link side has echoed the last one.
  cfg_wait_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (core.ack_s[1] != core.cfg_tog) |=> $stable(core.cfg_tog))
    else $error("config toggle moved before acknowledge");

  allpair_loss_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (act_c && lnk.pat == PAT_ALL && !last_ui) |=>
      bus_sample_pairs_out == '0)
    else $error("sample leaked into strobe pattern");

  marker_all_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    1'b1 |=>
      bus_frame_marker_pair_out == ($past(lnk.stb_en) & {NBUS{$past(last_ui)}}))
    else $error("marker pair outside last UI");

  mode_select_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.pat == PAT_ALL && req) |-> act_c)
    else $error("all-pairs mode not selected");

  cnt_step_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (!sr_edge && !last_ui) |=>
      lnk.cnt == $past(lnk.cnt) + 8'h01)
    else $error("frame counter skipped");

  zero_len_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.flen == 8'h00) |-> last_ui)
    else $error("zero length frame not one UI");

  flen_read_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (rd_in && addr_in == FRAME_LENGTH_ADDR) |=>
      rdata_out == {24'h000000, $past(core.flen)})
    else $error("frame length read wrong");

  swing_hold_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !(wr_in && addr_in == SWING_ADDR) |=> $stable(swing_out))
    else $error("swing changed without write");

  status_read_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (rd_in && addr_in == STATUS_ADDR) |=>
      rdata_out[DW-1:FCNT_LSB+8] == '0 && rdata_out[FCNT_LSB-1:ACT_BIT+1] == '0)
    else $error("status spare bits not zero");

  unmapped_read_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (rd_in && addr_in > STATUS_ADDR) |=> rdata_out == '0)
    else $error("unmapped read not zero");

  // Each request source is checked on its own so a swapped decode shows up.
  ts_source_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.src == SRC_TS && lnk.pat == PAT_ALL) |-> act_c == lnk.ts_s[1])
    else $error("request not from timestamp");

  spi_source_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.src == SRC_SPI && lnk.pat == PAT_ALL) |-> act_c == lnk.spi_s[1])
    else $error("request not from register bit");

  pin_lsb_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.src == SRC_PIN && lnk.pat == PAT_LSB) |-> act_c == lnk.pin_s[1])
    else $error("LSB request not from pin");

  no_pattern_a: assert property (
    @(posedge link_clk_in) disable iff (!nrst_in)
    (lnk.pat != PAT_LSB && lnk.pat != PAT_ALL) |-> !act_c)
    else $error("pattern active outside substitution modes");
endmodule : strobe_frame

/* frame_rx_model.sv */
// Receiver model that measures frame marker spacing and width.
`timescale 1ns/100ps
module frame_rx_model
  import strobe_frame_pkg::*;
(
  // Link side
  input wire logic link_clk_in,
  input wire logic nrst_in,
  input wire logic [strobe_frame_pkg::NBUS-1:0] marker_in,
  // Measurements
  output int gap_out,
  output int width_out
);
  int cnt = 0;
  int hi = 0;
  // Sampling mid-UI avoids racing the transmitter's launch edge.
  always @(negedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 0;
      hi <= 0;
      gap_out <= 0;
      width_out <= 0;
    end else begin
      cnt <= marker_in[0] ? 1 : cnt + 1;
      hi <= marker_in[0] ? hi + 1 : 0;
      if (marker_in[0]) gap_out <= cnt;
      if (!marker_in[0] && hi > 0) width_out <= hi;
    end
  end
endmodule : frame_rx_model

/* tb.sv */
// Self-checking bench for the strobe frame output stage.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import strobe_frame_pkg::*;
  logic mclk_in = 0, link_clk_in = 0, nrst_in = 0;
  logic [AW-1:0] addr_in = '0;
  logic [DW-1:0] wdata_in = '0;
  logic wr_in = 0, rd_in = 0, sref = 0, req = 0, ts = 0;
  logic [NBUS*SW-1:0] sample_in = {4{12'h5A5}};
  logic [DW-1:0] rdata_out;
  logic [NBUS*SW-1:0] bus_out;
  logic [NBUS-1:0] mk_out;
  logic [1:0] swing_out;
  int gap, width, n1, n2, fails = 0, checks = 0;
  strobe_frame dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .link_clk_in(link_clk_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .system_reference_input_in(sref),
    .single_ended_request_pin_in(req), .timestamp_input_in(ts), .sample_in(sample_in),
    .bus_sample_pairs_out(bus_out), .bus_frame_marker_pair_out(mk_out),
    .swing_out(swing_out));
  frame_rx_model rx_u (.link_clk_in(link_clk_in), .nrst_in(nrst_in), .marker_in(mk_out),
    .gap_out(gap), .width_out(width));
  always #5 mclk_in = ~mclk_in;
  always #40 link_clk_in = ~link_clk_in;
  task automatic report_and_stop;
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_out)
  endtask : rd
  task automatic lk(input int n);
    repeat (n) @(posedge link_clk_in);
  endtask : lk
  // Mode 0 expects plain samples, 2 the marker in bit 0, 3 the whole-word pattern.
  task automatic ui_chk(input logic [1:0] mode, input logic [3:0] en);
    logic [SW-1:0] s, w;
    for (int i = 0; i < 12; i++) begin
      @(posedge link_clk_in);
      #1;
      for (int b = 0; b < NBUS; b++) begin
        s = sample_in[b*SW +: SW];
        w = s;
        if (mode == PAT_LSB) w = {s[SW-1:1], mk_out[0]};
        if (mode == PAT_ALL) w = mk_out[0] ? WORD_ONES : WORD_ZERO;
        `CHK("word", w, bus_out[b*SW +: SW])
        `CHK("marker", mk_out[0] & en[b], mk_out[b])
      end
    end
  endtask : ui_chk
  task automatic t_regs;
    rd(PATTERN_CHOICE_ADDR, 32'h0000_0000);
    rd(LINK_CONTROL_ADDR, 32'h0000_00F0);
    rd(FRAME_LENGTH_ADDR, 32'h0000_0008);
    rd(SWING_ADDR, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    `CHK("swing", SWING_HIGH, swing_out)
    wr(SWING_ADDR, 32'h1);
    repeat (3) @(posedge mclk_in);
    `CHK("swing", SWING_LOW, swing_out)
    wr(SWING_ADDR, 32'h3);
    repeat (3) @(posedge mclk_in);
    `CHK("swing", SWING_HIZ, swing_out)
  endtask : t_regs
  task automatic t_frame;
    wr(FRAME_LENGTH_ADDR, 32'h5);
    @(posedge link_clk_in) req <= 1'b1;
    lk(14);
    ui_chk(2'h0, 4'hF);
    `CHK("gap", 5, gap)
    `CHK("width", 1, width)
  endtask : t_frame
  // Latency from the reference to the next marker must not depend on the old phase.
  task automatic sref_lat(output int n);
    @(posedge link_clk_in) sref <= 1'b1;
    lk(2);
    sref <= 1'b0;
    // Markers up to the third edge still belong to the old phase.
    lk(2);
    #1;
    n = 4;
    while (mk_out[0] !== 1'b1 && n < 40) begin
      @(posedge link_clk_in);
      #1;
      n++;
    end
  endtask : sref_lat
  task automatic t_sref;
    sref_lat(n1);
    lk(13);
    sref_lat(n2);
    `CHK("sref_lat", n1, n2)
    `CHK("sref_abs", 8, n1)
  endtask : t_sref
  task automatic t_modes;
    wr(PATTERN_CHOICE_ADDR, 32'h2);
    lk(12);
    ui_chk(PAT_LSB, 4'hF);
    @(posedge link_clk_in) req <= 1'b0;
    lk(6);
    ui_chk(2'h0, 4'hF);
    wr(LINK_CONTROL_ADDR, 32'h50);
    wr(PATTERN_CHOICE_ADDR, 32'h3);
    @(posedge link_clk_in) req <= 1'b1;
    lk(12);
    ui_chk(PAT_ALL, 4'h5);
    @(posedge link_clk_in) req <= 1'b0;
    lk(6);
    ui_chk(2'h0, 4'h5);
  endtask : t_modes
  task automatic t_src;
    wr(LINK_CONTROL_ADDR, 32'hF1);
    @(posedge link_clk_in) req <= 1'b1;
    lk(12);
    ui_chk(2'h0, 4'hF);
    wr(LINK_CONTROL_ADDR, 32'hF5);
    lk(12);
    ui_chk(PAT_ALL, 4'hF);
    wr(LINK_CONTROL_ADDR, 32'hF2);
    @(posedge link_clk_in) ts <= 1'b1;
    lk(12);
    ui_chk(PAT_ALL, 4'hF);
    @(posedge link_clk_in) ts <= 1'b0;
    lk(6);
    ui_chk(2'h0, 4'hF);
  endtask : t_src
  initial begin
    lk(8);
    nrst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    t_regs();
    t_frame();
    t_sref();
    t_modes();
    t_src();
    report_and_stop();
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule : tb
